// ==== pkg/bos_defines.vh ====
`ifndef BOS_DEFINES_VH
`define BOS_DEFINES_VH

// Register block nibble and offset
`define BOS_BLK_LINK 4'h0
`define BOS_BLK_BUF0 4'h6
`define BOS_BLK_BUF1 4'h7
`define BOS_BLK_INT 4'hA
`define BOS_OFF_SRC_SEL 8'h0A
`define BOS_OFF_LINK_CTRL 8'h13
`define BOS_OFF_REP_COUNT 8'h14
`define BOS_OFF_STATUS 8'h06
`define BOS_OFF_INT_CTRL 8'h01

// Field positions
`define BOS_DE_SEL_HI 3
`define BOS_DE_SEL_LO 2
`define BOS_CTL_MOS 0
`define BOS_CTL_IDLE 2
`define BOS_CTL_ABORT 3
`define BOS_REP_BUF 7
`define BOS_STS_SOT 6
`define BOS_STS_EOT 4
`define BOS_ICR_RUR 0

// Source codes for D or E timeslots
`define BOS_DE_SERIAL_A 2'h0
`define BOS_DE_HDLC 2'h1
`define BOS_DE_SERIAL_B 2'h2
`define BOS_DE_FRACT 2'h3

// Fixed patterns
`define BOS_ONES_BYTE 8'hFF
`define BOS_ONES_WORD 16'hFFFF
`define BOS_FLAG_WORD 16'h7E7E
`define BOS_YELLOW_BYTE 8'h00
`define BOS_ABORT_ONES 4'h9

// Reset values and bit positions
`define BOS_RST_BYTE 8'h00
`define BOS_RST_COUNT 7'h00
`define BOS_BIT_LAST 4'hF
`define BOS_BIT_HALF 4'h7

`endif

// ==== core/bos_word_shifter.v ====
`timescale 1ns/1ps
`include "bos_defines.vh"

// Rotating sixteen-bit codeword serializer, bit 0 out first
module bos_word_shifter (
  input wire clk,
  input wire srst,
  input wire load,
  input wire [15:0] word,
  input wire bitEn,
  output wire bitOut,
  output wire wordEnd,
  output wire byteEnd
);

  reg [15:0] shift_q; // Codeword being sent
  reg [3:0] idx_q; // Position of current bit

  // Load or rotate; rotation repeats the word with no gap
  always @(posedge clk) begin
    if (srst) begin
      shift_q <= `BOS_ONES_WORD;
      idx_q <= 4'h0;
    end else if (load) begin
      shift_q <= word;
      idx_q <= 4'h0;
    end else if (bitEn) begin
      shift_q <= {shift_q[0], shift_q[15:1]};
      idx_q <= idx_q + 4'h1;
    end
  end

  assign bitOut = shift_q[0];
  assign wordEnd = bitEn && (idx_q == `BOS_BIT_LAST);
  assign byteEnd = bitEn && (idx_q == `BOS_BIT_LAST || idx_q == `BOS_BIT_HALF);

endmodule

// ==== core/bos_tx_datalink.v ====
`timescale 1ns/1ps
`include "bos_defines.vh"

module bos_tx_datalink #(
  parameter DEPTH = 96, // Bytes per transmit buffer
  parameter PTRW = 7 // Pointer width for DEPTH
) (
  input wire clk,
  input wire srst,
  input wire [3:0] regBlock, // Register block nibble n
  input wire [7:0] regOffset, // Register offset in block
  input wire regWrEn, // One-cycle write strobe
  input wire regRdEn, // One-cycle read strobe
  input wire [7:0] regWrData,
  input wire [7:0] rxBuf0Data, // Receive buffer zero read data
  input wire [7:0] rxBuf1Data, // Receive buffer one read data
  input wire linkBitEn, // Data link bit opportunity pulse
  input wire serialPayloadInput, // Serial pin, asynchronous
  input wire fractionalPayloadInput, // Fractional pin, asynchronous
  output reg [7:0] regRdData_q,
  output reg regRdValid_q,
  output reg linkBit_q, // Data link bit toward the framer
  output reg deChannelBit_q, // Bit for D or E timeslots
  output reg transferDoneEvent_q, // One-cycle end of transfer pulse
  output reg sotFlag_q, // Sticky start of transfer
  output reg eotFlag_q // Sticky end of transfer
);

  // States of the signaling sequencer
  localparam ST_IDLE = 2'h0; // All ones
  localparam ST_SEND = 2'h1; // Codeword repetitions
  localparam ST_FLAG = 2'h2; // 0x7E idle flags
  localparam ST_ABORT = 2'h3; // Abort ones then all ones

  ////////////////////////////////////////////////////////////////////
  // Registers and storage
  reg [7:0] srcSel_q; // Source select register
  reg [7:0] linkCtrl_q; // Link control register
  reg [6:0] repCount_q; // Programmed repetition count
  reg intCtrl_q; // Clear on read when set
  reg nextBuf_q; // Next available transmit buffer
  reg [PTRW-1:0] wrPtr_q; // Load pointer of next buffer
  reg curBuf_q; // Buffer being sent
  reg [7:0] buf0Mem [0:DEPTH-1]; // Transmit buffer zero
  reg [7:0] buf1Mem [0:DEPTH-1]; // Transmit buffer one
  reg [1:0] state_q;
  reg [6:0] repLeft_q; // Repetitions still owed
  reg forever_q; // Count of zero or priority
  reg [3:0] abortCnt_q; // Abort ones sent
  reg [1:0] serSync_q; // Serial pin synchroniser
  reg [1:0] fracSync_q; // Fractional pin synchroniser

  ////////////////////////////////////////////////////////////////////
  // Decode
  wire selLink = regBlock == `BOS_BLK_LINK;
  wire selInt = regBlock == `BOS_BLK_INT;
  wire wrSrc = regWrEn && selLink && regOffset == `BOS_OFF_SRC_SEL;
  wire wrCtrl = regWrEn && selLink && regOffset == `BOS_OFF_LINK_CTRL;
  wire wrCount = regWrEn && selLink && regOffset == `BOS_OFF_REP_COUNT;
  wire wrBuf0 = regWrEn && regBlock == `BOS_BLK_BUF0;
  wire wrBuf1 = regWrEn && regBlock == `BOS_BLK_BUF1;
  wire wrStatus = regWrEn && selInt && regOffset == `BOS_OFF_STATUS;
  wire rdStatus = regRdEn && selInt && regOffset == `BOS_OFF_STATUS;
  wire wrIcr = regWrEn && selInt && regOffset == `BOS_OFF_INT_CTRL;
  wire wrNext = (wrBuf0 && !nextBuf_q) || (wrBuf1 && nextBuf_q);
  wire bosMode = !linkCtrl_q[`BOS_CTL_MOS];
  wire startXfer = wrCount && bosMode;
  wire abortReq = linkCtrl_q[`BOS_CTL_ABORT];
  wire idleIns = linkCtrl_q[`BOS_CTL_IDLE];

  // Message byte sits at location zero of the chosen buffer
  wire [7:0] startByte = nextBuf_q ? buf1Mem[0] : buf0Mem[0];
  wire [7:0] curByte = curBuf_q ? buf1Mem[0] : buf0Mem[0];
  wire startPrio = startByte == `BOS_YELLOW_BYTE;
  wire curPrio = curByte == `BOS_YELLOW_BYTE;

  ////////////////////////////////////////////////////////////////////
  // Serializer interface
  wire shBit;
  wire shWordEnd;
  wire shByteEnd;
  reg shLoad;
  reg [15:0] shWord;
  reg [1:0] state_d;

  // Next state and word load
  always @* begin
    state_d = state_q;
    shLoad = 1'b0;
    shWord = `BOS_ONES_WORD;
    if (startXfer) begin
      state_d = ST_SEND;
      shLoad = 1'b1;
      shWord = {startByte, `BOS_ONES_BYTE};
    end else begin
      case (state_q)
        ST_SEND: begin
          // Priority word ignores abort until replaced
          if (shByteEnd && abortReq && !curPrio) begin
            state_d = ST_ABORT;
            shLoad = 1'b1;
          end else if (shWordEnd && !forever_q && repLeft_q == 7'h01) begin
            // Counted repetitions finished
            if (idleIns) begin
              state_d = ST_FLAG;
              shLoad = 1'b1;
              shWord = `BOS_FLAG_WORD;
            end else begin
              state_d = ST_IDLE;
              shLoad = 1'b1;
            end
          end
        end
        ST_FLAG: begin
          // Abort after the flag byte in progress
          if (shByteEnd && abortReq) begin
            state_d = ST_ABORT;
            shLoad = 1'b1;
          end else if (shWordEnd && !idleIns) begin
            state_d = ST_IDLE;
            shLoad = 1'b1;
          end
        end
        ST_ABORT: begin
          // Leave once the nine ones are out and abort clears, or at once on a new start
          if (abortCnt_q == `BOS_ABORT_ONES && !abortReq) begin
            state_d = ST_IDLE;
          end
        end
        default: begin
          state_d = ST_IDLE;
        end
      endcase
    end
  end

  bos_word_shifter uShifter (
    .clk(clk),
    .srst(srst),
    .load(shLoad),
    .word(shWord),
    .bitEn(linkBitEn),
    .bitOut(shBit),
    .wordEnd(shWordEnd),
    .byteEnd(shByteEnd)
  );

  ////////////////////////////////////////////////////////////////////
  // Sequencer, repetition count and end event
  always @(posedge clk) begin
    if (srst) begin
      state_q <= ST_IDLE;
      repLeft_q <= `BOS_RST_COUNT;
      forever_q <= 1'b0;
      abortCnt_q <= 4'h0;
      curBuf_q <= 1'b0;
      transferDoneEvent_q <= 1'b0;
    end else begin
      state_q <= state_d;
      transferDoneEvent_q <= 1'b0;
      if (startXfer) begin
        // Latch count; zero means endless
        curBuf_q <= nextBuf_q;
        repLeft_q <= regWrData[6:0];
        forever_q <= regWrData[6:0] == `BOS_RST_COUNT || startPrio;
      end else if (state_q == ST_SEND && shWordEnd && !forever_q) begin
        repLeft_q <= repLeft_q - 7'h01;
        if (repLeft_q == 7'h01) begin
          transferDoneEvent_q <= 1'b1;
        end
      end
      // Count abort ones, saturating at nine
      if (state_q != ST_ABORT) begin
        abortCnt_q <= 4'h0;
      end else if (linkBitEn && abortCnt_q != `BOS_ABORT_ONES) begin
        abortCnt_q <= abortCnt_q + 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Data link bit: one per opportunity, ones outside codewords and idle flags
  always @(posedge clk) begin
    if (srst) begin
      linkBit_q <= 1'b1;
    end else if (linkBitEn) begin
      if (state_q == ST_SEND || state_q == ST_FLAG) begin
        linkBit_q <= shBit;
      end else begin
        linkBit_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  always @(posedge clk) begin
    if (srst) begin
      serSync_q <= 2'h0;
      fracSync_q <= 2'h0;
    end else begin
      serSync_q <= {serSync_q[0], serialPayloadInput};
      fracSync_q <= {fracSync_q[0], fractionalPayloadInput};
    end
  end

  // D or E timeslot source mux
  always @(posedge clk) begin
    if (srst) begin
      deChannelBit_q <= 1'b1;
    end else begin
      case (srcSel_q[`BOS_DE_SEL_HI:`BOS_DE_SEL_LO])
        `BOS_DE_HDLC: deChannelBit_q <= linkBit_q;
        `BOS_DE_FRACT: deChannelBit_q <= fracSync_q[1];
        default: deChannelBit_q <= serSync_q[1];
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Control registers
  always @(posedge clk) begin
    if (srst) begin
      srcSel_q <= `BOS_RST_BYTE;
      linkCtrl_q <= `BOS_RST_BYTE;
      repCount_q <= `BOS_RST_COUNT;
      intCtrl_q <= 1'b0;
    end else begin
      if (wrSrc) begin
        srcSel_q <= regWrData;
      end
      if (wrCtrl) begin
        linkCtrl_q <= regWrData;
      end
      if (wrCount) begin
        repCount_q <= regWrData[6:0];
      end
      if (wrIcr) begin
        intCtrl_q <= regWrData[`BOS_ICR_RUR];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Ping-pong buffer loading
  always @(posedge clk) begin
    if (srst) begin
      nextBuf_q <= 1'b0;
      wrPtr_q <= {PTRW{1'b0}};
    end else if (startXfer) begin
      // Sending buffer is taken; loading moves to the other
      nextBuf_q <= !nextBuf_q;
      wrPtr_q <= {PTRW{1'b0}};
    end else if (wrNext) begin
      if (wrPtr_q == DEPTH[PTRW-1:0] - {{(PTRW-1){1'b0}}, 1'b1}) begin
        nextBuf_q <= !nextBuf_q;
        wrPtr_q <= {PTRW{1'b0}};
      end else begin
        wrPtr_q <= wrPtr_q + {{(PTRW-1){1'b0}}, 1'b1};
      end
    end
  end

  // Buffer storage; writes to the port of the busy buffer are dropped
  always @(posedge clk) begin
    if (wrBuf0 && !nextBuf_q) begin
      buf0Mem[wrPtr_q] <= regWrData;
    end
    if (wrBuf1 && nextBuf_q) begin
      buf1Mem[wrPtr_q] <= regWrData;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Sticky transfer flags, set wins over clear
  always @(posedge clk) begin
    if (srst) begin
      sotFlag_q <= 1'b0;
      eotFlag_q <= 1'b0;
    end else begin
      if (startXfer) begin
        sotFlag_q <= 1'b1;
      end else if ((rdStatus && intCtrl_q) ||
                   (wrStatus && !intCtrl_q && regWrData[`BOS_STS_SOT])) begin
        sotFlag_q <= 1'b0;
      end
      if (state_q == ST_SEND && shWordEnd && !forever_q && repLeft_q == 7'h01) begin
        eotFlag_q <= 1'b1;
      end else if ((rdStatus && intCtrl_q) ||
                   (wrStatus && !intCtrl_q && regWrData[`BOS_STS_EOT])) begin
        eotFlag_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Register read path, one cycle latency
  always @(posedge clk) begin
    if (srst) begin
      regRdData_q <= `BOS_RST_BYTE;
      regRdValid_q <= 1'b0;
    end else begin
      regRdValid_q <= regRdEn;
      if (regRdEn) begin
        regRdData_q <= `BOS_RST_BYTE;
        if (regBlock == `BOS_BLK_BUF0) begin
          regRdData_q <= rxBuf0Data;
        end else if (regBlock == `BOS_BLK_BUF1) begin
          regRdData_q <= rxBuf1Data;
        end else if (selLink && regOffset == `BOS_OFF_SRC_SEL) begin
          regRdData_q <= srcSel_q;
        end else if (selLink && regOffset == `BOS_OFF_LINK_CTRL) begin
          regRdData_q <= linkCtrl_q;
        end else if (selLink && regOffset == `BOS_OFF_REP_COUNT) begin
          regRdData_q <= {nextBuf_q, repCount_q};
        end else if (rdStatus) begin
          regRdData_q[`BOS_STS_SOT] <= sotFlag_q;
          regRdData_q[`BOS_STS_EOT] <= eotFlag_q;
        end else if (selInt && regOffset == `BOS_OFF_INT_CTRL) begin
          regRdData_q[`BOS_ICR_RUR] <= intCtrl_q;
        end
      end
    end
  end

endmodule

// ==== tb/bos_link_receiver.sv ====
`timescale 1ns/1ps

// Far-end model: offers link bit slots and records what arrives
module bos_link_receiver (
  input wire clk,
  input wire srst,
  input wire slow,
  input wire lineBit,
  output reg linkBitEn,
  output reg [63:0] hist_q,
  output reg [15:0] bitCnt_q
);
  reg [2:0] div_q; // Slot spacing counter
  reg take_q; // Bit is settled, capture it

  ////////////////////////////////////////////////////////////
  // Slot every 4 cycles, or 5 when slow, no gaps between
  always @(posedge clk) begin
    if (srst) begin
      div_q <= 3'h0;
      linkBitEn <= 1'b0;
      take_q <= 1'b0;
      hist_q <= 64'h0;
      bitCnt_q <= 16'h0;
    end else begin
      div_q <= (div_q == (slow ? 3'h4 : 3'h3)) ? 3'h0 : div_q + 3'h1;
      linkBitEn <= (div_q == 3'h0);
      take_q <= linkBitEn;
      // Newest bit lands in bit 0
      if (take_q) begin
        hist_q <= {hist_q[62:0], lineBit};
        bitCnt_q <= bitCnt_q + 16'h1;
      end
    end
  end
endmodule

// ==== tb/bos_tx_datalink_monitor.sv ====
`timescale 1ns/1ps

// Port-level checker of the transmit link block
module bos_tx_datalink_monitor (
  input wire clk,
  input wire srst,
  input wire [3:0] regBlock,
  input wire [7:0] regOffset,
  input wire regWrEn,
  input wire regRdEn,
  input wire [7:0] regWrData,
  input wire [7:0] rxBuf0Data,
  input wire [7:0] rxBuf1Data,
  input wire linkBitEn,
  input wire serialPayloadInput,
  input wire fractionalPayloadInput,
  input wire [7:0] regRdData_q,
  input wire regRdValid_q,
  input wire linkBit_q,
  input wire deChannelBit_q,
  input wire transferDoneEvent_q,
  input wire sotFlag_q,
  input wire eotFlag_q
);
  reg [1:0] srcSel_q; // Shadow of D/E source code
  reg mos_q; // Shadow of message mode bit
  wire ctlWr = regWrEn && regBlock == 4'h0; // Link block write

  ////////////////////////////////////////////////////////////
  // Shadow registers follow host writes
  always @(posedge clk) begin
    if (srst) begin
      srcSel_q <= 2'h0;
      mos_q <= 1'b0;
    end else if (ctlWr && regOffset == 8'h0A) begin
      srcSel_q <= regWrData[3:2];
    end else if (ctlWr && regOffset == 8'h13) begin
      mos_q <= regWrData[0];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_start;
    ctlWr && regOffset == 8'h14 && !mos_q;
  endsequence
  sequence s_doneTail;
    eotFlag_q ##1 !transferDoneEvent_q;
  endsequence

  ////////////////////////////////////////////////////////////
  a_read_valid: assert property (regRdEn |=> regRdValid_q)
    else $error("read answer missing");
  a_buf0_read: assert property (regRdEn && regBlock == 4'h6 |=>
    regRdData_q == $past(rxBuf0Data)) else $error("port zero read wrong");
  a_buf1_read: assert property (regRdEn && regBlock == 4'h7 |=>
    regRdData_q == $past(rxBuf1Data)) else $error("port one read wrong");
  a_data_hold: assert property (!regRdEn |=> $stable(regRdData_q))
    else $error("read data moved");
  a_link_hold: assert property (!linkBitEn |=> $stable(linkBit_q))
    else $error("link bit moved off slot");
  a_start_flag: assert property (s_start |=> sotFlag_q)
    else $error("start flag missing");
  a_done_pulse: assert property (transferDoneEvent_q |-> s_doneTail)
    else $error("end event malformed");
  a_done_slot: assert property (transferDoneEvent_q |-> $past(linkBitEn))
    else $error("end event off slot");
  a_eot_sticky: assert property (eotFlag_q && !regWrEn && !regRdEn |=> eotFlag_q)
    else $error("end flag dropped");
  a_fract_path: assert property ((srcSel_q == 2'h3) [*4] |->
    deChannelBit_q == $past(fractionalPayloadInput, 3)) else $error("fractional path");
  a_serial_path: assert property ((!srcSel_q[0]) [*4] |->
    deChannelBit_q == $past(serialPayloadInput, 3)) else $error("serial path");
endmodule

bind bos_tx_datalink bos_tx_datalink_monitor u_mon (.clk(clk), .srst(srst),
  .regBlock(regBlock), .regOffset(regOffset), .regWrEn(regWrEn), .regRdEn(regRdEn),
  .regWrData(regWrData), .rxBuf0Data(rxBuf0Data), .rxBuf1Data(rxBuf1Data),
  .linkBitEn(linkBitEn), .serialPayloadInput(serialPayloadInput),
  .fractionalPayloadInput(fractionalPayloadInput), .regRdData_q(regRdData_q),
  .regRdValid_q(regRdValid_q), .linkBit_q(linkBit_q), .deChannelBit_q(deChannelBit_q),
  .transferDoneEvent_q(transferDoneEvent_q), .sotFlag_q(sotFlag_q), .eotFlag_q(eotFlag_q));

// ==== tb/bos_tx_datalink_tb.sv ====
`timescale 1ns/1ps

module bos_tx_datalink_tb;
  reg clk = 1'b0;
  reg srst = 1'b1;
  reg [3:0] regBlock = 4'h0;
  reg [7:0] regOffset = 8'h00;
  reg regWrEn = 1'b0;
  reg regRdEn = 1'b0;
  reg [7:0] regWrData = 8'h00;
  reg [7:0] rxBuf0Data = 8'hA5; // Receive side contents
  reg [7:0] rxBuf1Data = 8'h3C;
  reg serPin = 1'b0;
  reg frPin = 1'b0;
  reg slow = 1'b0;
  wire linkBitEn, linkBit, deBit, doneEv, sot, eot, rdValid;
  wire [7:0] rdData;
  wire [63:0] hist;
  wire [15:0] bitCnt;
  reg [15:0] base; // Bit count at transfer start
  integer mismatches = 0;
  integer checked = 0;
  integer cycles = 0;
  integer doneCnt = 0; // End of transfer pulses seen
  integer i, k;

  always #5 clk = ~clk;

  bos_tx_datalink u_dut (.clk(clk), .srst(srst), .regBlock(regBlock),
    .regOffset(regOffset), .regWrEn(regWrEn), .regRdEn(regRdEn), .regWrData(regWrData),
    .rxBuf0Data(rxBuf0Data), .rxBuf1Data(rxBuf1Data), .linkBitEn(linkBitEn),
    .serialPayloadInput(serPin), .fractionalPayloadInput(frPin), .regRdData_q(rdData),
    .regRdValid_q(rdValid), .linkBit_q(linkBit), .deChannelBit_q(deBit),
    .transferDoneEvent_q(doneEv), .sotFlag_q(sot), .eotFlag_q(eot));

  bos_link_receiver u_far (.clk(clk), .srst(srst), .slow(slow), .lineBit(linkBit),
    .linkBitEn(linkBitEn), .hist_q(hist), .bitCnt_q(bitCnt));

  ////////////////////////////////////////////////////////////
  // Shared compare, bus cycles and bit collection
  task chk(input string nm, input [63:0] e, input [63:0] g);
    checked = checked + 1;
    if (g !== e) begin
      mismatches = mismatches + 1;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task wr(input [3:0] b, input [7:0] o, input [7:0] d);
    regBlock <= b;
    regOffset <= o;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clk);
    regWrEn <= 1'b0;
    @(posedge clk);
  endtask

  task rd(input [3:0] b, input [7:0] o, input [7:0] e, input string nm);
    regBlock <= b;
    regOffset <= o;
    regRdEn <= 1'b1;
    @(posedge clk);
    regRdEn <= 1'b0;
    @(posedge clk);
    chk("read valid", 1, rdValid);
    chk(nm, e, rdData);
  endtask

  task waitBits(input [15:0] n);
    while (bitCnt - base < n) @(posedge clk);
  endtask

  // Start right after a slot, then check n bits: first word, then next
  task run(input [6:0] c, input [15:0] w1, input [15:0] w2, input [7:0] n);
    do @(posedge clk); while (linkBitEn !== 1'b1);
    wr(4'h0, 8'h14, {1'b0, c});
    base = bitCnt;
    waitBits(n);
    for (k = 0; k < n; k = k + 1) begin
      chk("link bit", (k < 16) ? w1[k % 16] : w2[k % 16], hist[n - 1 - k]);
    end
    @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////
  // Scenarios
  task s_regs;
    rd(4'h0, 8'h0A, 8'h00, "source select");
    rd(4'h0, 8'h14, 8'h00, "repeat count");
    rd(4'hA, 8'h06, 8'h00, "status");
    rd(4'h0, 8'h55, 8'h00, "unmapped");
    rd(4'h6, 8'h00, 8'hA5, "port zero");
    rd(4'h7, 8'h00, 8'h3C, "port one");
  endtask

  task s_count;
    wr(4'h6, 8'h00, 8'h56);
    run(7'h0A, 16'h56FF, 16'h56FF, 64);
    chk("start flag", 1, sot);
    // Ten words: no end before bit 160, end right after it
    waitBits(159);
    chk("end flag early", 0, eot);
    waitBits(160);
    chk("end flag", 1, eot);
    chk("end events", 1, doneCnt);
    rd(4'h0, 8'h14, 8'h8A, "next buffer one");
    rd(4'hA, 8'h06, 8'h50, "status set");
    rd(4'hA, 8'h06, 8'h50, "status kept");
    wr(4'hA, 8'h06, 8'h50);
    rd(4'hA, 8'h06, 8'h00, "status cleared");
  endtask

  task s_idle;
    wr(4'hA, 8'h01, 8'h01);
    wr(4'h0, 8'h13, 8'h04);
    wr(4'h7, 8'h00, 8'h2A);
    run(7'h01, 16'h2AFF, 16'h7E7E, 32);
    rd(4'hA, 8'h06, 8'h50, "status on read");
    rd(4'hA, 8'h06, 8'h00, "status after read");
    rd(4'h0, 8'h14, 8'h01, "next buffer zero");
  endtask

  // Endless count and the priority word, slow slots
  task s_endless;
    slow <= 1'b1;
    wr(4'h6, 8'h00, 8'h14);
    run(7'h00, 16'h14FF, 16'h14FF, 64);
    chk("no end flag", 0, eot);
    // Yellow word held by software, count ignored
    wr(4'h7, 8'h00, 8'h00);
    run(7'h03, 16'h00FF, 16'h00FF, 64);
    chk("no end flag", 0, eot);
    chk("end events", 2, doneCnt);
    slow <= 1'b0;
  endtask

  task s_abort;
    wr(4'h6, 8'h00, 8'h56);
    run(7'h00, 16'h56FF, 16'h56FF, 16);
    wr(4'h0, 8'h13, 8'h08);
    base = bitCnt;
    waitBits(40);
    chk("abort ones", 64'hFFFFFF, hist[23:0]);
  endtask

  // D/E source codes with link held at ones
  task s_desel;
    for (i = 0; i < 8; i = i + 1) begin
      serPin <= i[2];
      frPin <= !i[2];
      wr(4'h0, 8'h0A, {4'h0, i[1:0], 2'h0});
      repeat (5) @(posedge clk);
      chk("de bit", i[0] ? (!i[1] || !i[2]) : i[2], deBit);
      rd(4'h0, 8'h0A, {4'h0, i[1:0], 2'h0}, "source readback");
    end
  endtask

  task stop_test;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Hang guard
  always @(posedge clk) begin
    cycles = cycles + 1;
    // Count end of transfer pulses
    if (doneEv === 1'b1) begin
      doneCnt = doneCnt + 1;
    end
    if (cycles == 8000) begin
      mismatches = mismatches + 1;
      stop_test;
    end
  end

  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    s_regs;
    s_count;
    s_idle;
    s_endless;
    s_abort;
    s_desel;
    stop_test;
  end
endmodule
